// File: common/lhci_params.svh
// constants for the lcd host command interface
`ifndef LHCI_PARAMS_SVH
`define LHCI_PARAMS_SVH

// command codes seen on a command write
`define LHCI_CMD_SYS_SETUP    8'h40
`define LHCI_CMD_SLEEP_IN     8'h53
`define LHCI_CMD_OVERLAY      8'h5b
`define LHCI_CMD_PIXEL_SCROLL 8'h5a
`define LHCI_CMD_CURSOR_LOAD  8'h46
`define LHCI_CMD_CURSOR_READ  8'h47
`define LHCI_CMD_MEM_STORE    8'h42
`define LHCI_CMD_MEM_FETCH    8'h43
`define LHCI_CMD_STEP_RIGHT   8'h4c
`define LHCI_CMD_STEP_LEFT    8'h4d
`define LHCI_CMD_STEP_UP      8'h4e
`define LHCI_CMD_STEP_DOWN    8'h4f

// overlay parameter field positions
`define LHCI_OVL_MX0_BIT      0
`define LHCI_OVL_MX1_BIT      1
`define LHCI_OVL_BLK1_BIT     2
`define LHCI_OVL_BLK3_BIT     3
`define LHCI_OVL_LAYER_BIT    4

// status byte: retrace flag position
`define LHCI_RETRACE_BIT      6

// wishbone register byte offsets
`define LHCI_REG_STATUS       8'h00
`define LHCI_REG_CURSOR       8'h04
`define LHCI_REG_PITCH        8'h08
`define LHCI_REG_MODE         8'h0c

// reset values
`define LHCI_PITCH_RESET      16'h0028
`define LHCI_CURSOR_RESET     16'h0000

`endif

// File: common/lhci_pkg.sv
// types for the lcd host command interface
package lhci_pkg;

   // command interpreter states, one-hot
   typedef enum logic [6:0] {
      LHCI_ST_IDLE     = 7'b0000001,
      LHCI_ST_CUR_LOAD = 7'b0000010,
      LHCI_ST_SCROLL   = 7'b0000100,
      LHCI_ST_OVERLAY  = 7'b0001000,
      LHCI_ST_STORE    = 7'b0010000,
      LHCI_ST_FETCH    = 7'b0100000,
      LHCI_ST_READBACK = 7'b1000000
   } lhci_state_type;

   // cursor auto-increment direction
   typedef enum logic [1:0] {
      LHCI_DIR_RIGHT = 2'b00,
      LHCI_DIR_LEFT  = 2'b01,
      LHCI_DIR_UP    = 2'b10,
      LHCI_DIR_DOWN  = 2'b11
   } lhci_dir_type;

endpackage

// File: logic/lhci_top.sv
// lcd host command interface: mcu bus decode, command interpreter, cursor and memory port
//
// Contract
// - block 1 and block 3 mode bits: 0 text, 1 graphics.
// - blocks 2 and 4 are always graphics.
// - layer bit: 0 two-layer, 1 three-layer composition.
// - pixel scroll takes one byte; low three bits give 0 to 7 pixels.
// - pixel scroll offset applies to the whole composed screen.
// - cursor load command: first byte low, second byte high.
// - cursor changes only by load or auto increment, not by scrolling.
// - accesses continue from last loaded address plus increments.
// - cursor readback gives low byte, then high byte.
// - each stored byte goes to cursor, then cursor steps.
// - fetch command enters output state and prefetches byte at cursor.
// - each buffer read steps cursor and fetches next byte.
// - with cursor shown, fetched data is two positions ahead.
// - separate strobe decode of status, data read, data write, command.
// - two select pins pick strobe style; enable style decodes alike.
// - each command completes within one bus cycle, no handshake needed.
// - status read drives retrace flag on data bit 6.
// - in sleep only system setup and sleep entry are accepted.
// - step commands 4c..4f choose right, left, up, down steps.
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "lhci_params.svh"

module lhci_top (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    resetn,
   // mcu parallel bus
   input  wire logic                    bus_style_sel_a,
   input  wire logic                    bus_style_sel_b,
   input  wire logic                    host_cs_n,
   input  wire logic                    register_select,
   input  wire logic                    host_rd_n_or_dir,
   input  wire logic                    host_wr_n_or_en,
   input  wire logic [7:0]              host_data_in,
   output logic      [7:0]              host_data_out,
   output logic                         host_data_oe,
   // display side
   input  wire logic                    retrace_in,
   input  wire logic                    cursor_shown,
   output logic                         block1_graphics_sel,
   output logic                         block3_graphics_sel,
   output logic      [3:0]              block_graphics,
   output logic                         three_layer_sel,
   output logic      [1:0]              compose_method,
   output logic      [2:0]              pixel_scroll,
   output logic      [15:0]             cursor_addr,
   output logic                         sleep_active,
   // display memory port
   output logic      [15:0]             vram_addr,
   output logic      [7:0]              vram_wdata,
   output logic                         vram_we,
   output logic                         vram_re,
   input  wire logic [7:0]              vram_rdata,
   // wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o
);
   import lhci_pkg::*;

   lhci_state_type state_q;
   lhci_state_type state_d;
   lhci_dir_type   dir_q;
   logic [15:0]    cursor_q;
   logic [15:0]    pitch_q;
   logic           pidx_q;
   logic [4:0]     overlay_q;
   logic [2:0]     scroll_q;
   logic           sleep_q;
   logic           rd_q;
   logic           wr_q;
   logic [7:0]     dout_q;
   logic [7:0]     fetch_buf_q;
   logic           fetch_pend_q;
   logic [15:0]    vram_addr_q;
   logic [7:0]     vram_wdata_q;
   logic           vram_we_q;
   logic           vram_re_q;
   logic           wb_ack_q;
   logic [31:0]    wb_dat_q;

   // bus style: sel_a high with sel_b low is direction plus enable, else separate strobes
   wire style_dir_en = bus_style_sel_a & ~bus_style_sel_b;
   wire rd_sep       = ~host_cs_n & ~host_rd_n_or_dir;
   wire wr_sep       = ~host_cs_n & ~host_wr_n_or_en;
   wire rd_de        = ~host_cs_n & host_wr_n_or_en & host_rd_n_or_dir;
   wire wr_de        = ~host_cs_n & host_wr_n_or_en & ~host_rd_n_or_dir;
   wire rd_now       = style_dir_en ? rd_de : rd_sep;
   wire wr_now       = style_dir_en ? wr_de : wr_sep;

   // act once per access, at the edge the strobe is first seen
   wire rd_start     = rd_now & ~rd_q;
   wire wr_start     = wr_now & ~wr_q;
   wire cmd_wr       = wr_start & register_select;
   wire dat_wr       = wr_start & ~register_select;
   wire stat_rd      = rd_start & ~register_select;
   wire dat_rd       = rd_start & register_select;

   // sleep lets only setup and sleep entry through
   wire cmd_allowed  = ~sleep_q
                     | (host_data_in == `LHCI_CMD_SYS_SETUP)
                     | (host_data_in == `LHCI_CMD_SLEEP_IN);
   wire cmd_take     = cmd_wr & cmd_allowed;

   // per-access cursor step; vertical moves use the address pitch
   wire [15:0] step_val = (dir_q == LHCI_DIR_RIGHT) ? 16'h0001 :
                          (dir_q == LHCI_DIR_LEFT)  ? 16'hffff :
                          (dir_q == LHCI_DIR_UP)    ? 16'(16'h0000 - pitch_q) :
                                                      pitch_q;
   wire [15:0] cursor_next = 16'(cursor_q + step_val);

   // store and fetch each advance the cursor once
   wire store_now  = dat_wr & (state_q == LHCI_ST_STORE);
   wire fetch_read = dat_rd & (state_q == LHCI_ST_FETCH);
   wire fetch_cmd  = cmd_take & (host_data_in == `LHCI_CMD_MEM_FETCH);
   wire load_low   = dat_wr & (state_q == LHCI_ST_CUR_LOAD) & ~pidx_q;
   wire load_high  = dat_wr & (state_q == LHCI_ST_CUR_LOAD) & pidx_q;

   // fetch address base: cursor now, or the stepped cursor after a buffer read
   wire [15:0] fetch_base = fetch_read ? cursor_next : cursor_q;
   // shown cursor trails the read pointer by two positions
   wire [15:0] fetch_addr = cursor_shown ?
                            16'(fetch_base + {step_val[14:0], 1'b0}) : fetch_base;

   // byte presented on a data read
   wire [7:0] data_rd_val = (state_q == LHCI_ST_READBACK) ?
                            (pidx_q ? cursor_q[15:8] : cursor_q[7:0]) :
                            fetch_buf_q;
   wire [7:0] status_val  = 8'(retrace_in) << `LHCI_RETRACE_BIT;

   // command decode to the next interpreter state
   always_comb begin
      state_d = state_q;
      if (cmd_take) begin
         case (host_data_in)
            `LHCI_CMD_CURSOR_LOAD:  state_d = LHCI_ST_CUR_LOAD;
            `LHCI_CMD_PIXEL_SCROLL: state_d = LHCI_ST_SCROLL;
            `LHCI_CMD_OVERLAY:      state_d = LHCI_ST_OVERLAY;
            `LHCI_CMD_MEM_STORE:    state_d = LHCI_ST_STORE;
            `LHCI_CMD_MEM_FETCH:    state_d = LHCI_ST_FETCH;
            `LHCI_CMD_CURSOR_READ:  state_d = LHCI_ST_READBACK;
            default:                state_d = LHCI_ST_IDLE;
         endcase
      end else if (cmd_wr) begin
         state_d = LHCI_ST_IDLE;
      end else if (dat_wr) begin
         case (state_q)
            LHCI_ST_SCROLL:   state_d = LHCI_ST_IDLE;
            LHCI_ST_OVERLAY:  state_d = LHCI_ST_IDLE;
            LHCI_ST_CUR_LOAD: state_d = pidx_q ? LHCI_ST_IDLE : LHCI_ST_CUR_LOAD;
            default:          state_d = state_q;
         endcase
      end else if (dat_rd) begin
         case (state_q)
            LHCI_ST_READBACK: state_d = pidx_q ? LHCI_ST_IDLE : LHCI_ST_READBACK;
            default:          state_d = state_q;
         endcase
      end
   end

   // strobe history and interpreter state
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         state_q <= LHCI_ST_IDLE;
      end else begin
         rd_q    <= rd_now;
         wr_q    <= wr_now;
         state_q <= state_d;
      end
   end

   // parameter byte index: resets on each command, flips on each byte of a two-byte parameter
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pidx_q <= 1'b0;
      end else if (cmd_wr) begin
         pidx_q <= 1'b0;
      end else if (load_low | load_high) begin
         pidx_q <= ~pidx_q;
      end else if (dat_rd & (state_q == LHCI_ST_READBACK)) begin
         pidx_q <= ~pidx_q;
      end
   end

   // sleep flag: sleep entry sets it, system setup clears it
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sleep_q <= 1'b0;
      end else if (cmd_take & (host_data_in == `LHCI_CMD_SLEEP_IN)) begin
         sleep_q <= 1'b1;
      end else if (cmd_take & (host_data_in == `LHCI_CMD_SYS_SETUP)) begin
         sleep_q <= 1'b0;
      end
   end

   // direction commands carry no parameter
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dir_q <= LHCI_DIR_RIGHT;
      end else if (cmd_take && host_data_in[7:2] == 6'h13) begin
         dir_q <= lhci_dir_type'(host_data_in[1:0]);
      end
   end

   // overlay and scroll parameters; scroll ignores the upper five bits
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         overlay_q <= 5'h00;
         scroll_q  <= 3'h0;
      end else if (dat_wr & (state_q == LHCI_ST_OVERLAY)) begin
         overlay_q <= host_data_in[4:0];
      end else if (dat_wr & (state_q == LHCI_ST_SCROLL)) begin
         scroll_q  <= host_data_in[2:0];
      end
   end

   // cursor: only load and auto increment touch it, scrolling never does
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cursor_q <= `LHCI_CURSOR_RESET;
      end else if (load_low) begin
         cursor_q <= {cursor_q[15:8], host_data_in};
      end else if (load_high) begin
         cursor_q <= {host_data_in, cursor_q[7:0]};
      end else if (store_now | fetch_read) begin
         cursor_q <= cursor_next;
      end
   end

   // memory port requests, one cycle each
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         vram_addr_q  <= 16'h0000;
         vram_wdata_q <= 8'h00;
         vram_we_q    <= 1'b0;
         vram_re_q    <= 1'b0;
      end else begin
         vram_we_q <= store_now;
         vram_re_q <= fetch_cmd | fetch_read;
         if (store_now) begin
            vram_addr_q  <= cursor_q;
            vram_wdata_q <= host_data_in;
         end else if (fetch_cmd | fetch_read) begin
            vram_addr_q  <= fetch_addr;
         end
      end
   end

   // memory answers the cycle after a read request; buffer holds it for the host
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fetch_pend_q <= 1'b0;
         fetch_buf_q  <= 8'h00;
      end else begin
         fetch_pend_q <= vram_re_q;
         if (fetch_pend_q) begin
            fetch_buf_q <= vram_rdata;
         end
      end
   end

   // read data register, loaded when a read strobe is first seen
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dout_q <= 8'h00;
      end else if (stat_rd) begin
         dout_q <= status_val;
      end else if (dat_rd) begin
         dout_q <= data_rd_val;
      end
   end

   // wishbone: ack one cycle after the request, dropped the next cycle
   wire wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_q;
   wire sel_status = (wb_adr_i == `LHCI_REG_STATUS);
   wire sel_cursor = (wb_adr_i == `LHCI_REG_CURSOR);
   wire sel_pitch  = (wb_adr_i == `LHCI_REG_PITCH);
   wire sel_mode   = (wb_adr_i == `LHCI_REG_MODE);
   wire [31:0] wb_rd_val = sel_status ? {24'h000000, state_q, sleep_q} :
                           sel_cursor ? {16'h0000, cursor_q} :
                           sel_pitch  ? {16'h0000, pitch_q} :
                           sel_mode   ? {19'h00000, dir_q, scroll_q, overlay_q, 3'h0} :
                                        32'h00000000;

   // pitch register steers vertical cursor steps; unmapped reads give zero
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h00000000;
         pitch_q  <= `LHCI_PITCH_RESET;
      end else begin
         wb_ack_q <= wb_req;
         if (wb_req) begin
            wb_dat_q <= wb_we_i ? 32'h00000000 : wb_rd_val;
         end
         if (wb_req & wb_we_i & sel_pitch & wb_sel_i[0]) begin
            pitch_q[7:0] <= wb_dat_i[7:0];
         end
         if (wb_req & wb_we_i & sel_pitch & wb_sel_i[1]) begin
            pitch_q[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // outputs
   assign host_data_out       = dout_q;
   assign host_data_oe        = rd_now;
   assign block1_graphics_sel = overlay_q[`LHCI_OVL_BLK1_BIT];
   assign block3_graphics_sel = overlay_q[`LHCI_OVL_BLK3_BIT];
   assign block_graphics      = {1'b1, block3_graphics_sel, 1'b1, block1_graphics_sel};
   assign three_layer_sel     = overlay_q[`LHCI_OVL_LAYER_BIT];
   assign compose_method      = {overlay_q[`LHCI_OVL_MX1_BIT], overlay_q[`LHCI_OVL_MX0_BIT]};
   assign pixel_scroll        = scroll_q;
   assign cursor_addr         = cursor_q;
   assign sleep_active        = sleep_q;
   assign vram_addr           = vram_addr_q;
   assign vram_wdata          = vram_wdata_q;
   assign vram_we             = vram_we_q;
   assign vram_re             = vram_re_q;
   assign wb_dat_o            = wb_dat_q;
   assign wb_ack_o            = wb_ack_q;

endmodule // lhci_top

`default_nettype wire

// File: sim/lhci_host_model.sv
// host microprocessor model on the parallel bus
`timescale 1ns/1ns
`default_nettype none
module lhci_host_model (
   // clock and strobe style
   input wire logic       sys_clk,
   input wire logic       style_en,
   // parallel bus
   output logic           cs_n,
   output logic           rs,
   output logic           rd_dir,
   output logic           wr_en,
   output logic     [7:0] dout,
   input wire logic [7:0] din,
   // byte taken by a read
   output logic           rd_done,
   output logic     [7:0] rd_byte
);
   // bus idle at start
   initial begin
      cs_n = 1'b1;
      rs = 1'b0;
      rd_dir = 1'b1;
      wr_en = 1'b1;
      dout = 8'h00;
      rd_done = 1'b0;
      rd_byte = 8'h00;
   end
   // idle strobe levels differ per style
   task automatic idle();
      rd_dir <= !style_en;
      wr_en <= !style_en;
   endtask
   // drive, hold over the taking edge, release, leave one idle edge
   task automatic acc(input logic a0, input logic is_rd, input logic [7:0] d);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      rs <= a0;
      dout <= is_rd ? ~dout : d;
      rd_dir <= style_en ? is_rd : !is_rd;
      wr_en <= style_en | is_rd;
      repeat (2) @(posedge sys_clk);
      rd_byte <= din;
      rd_done <= is_rd;
      cs_n <= 1'b1;
      rs <= ~rs;     // released lines must not keep their last value
      dout <= ~dout;
      idle();
      @(posedge sys_clk);
      rd_done <= 1'b0;
   endtask
endmodule // lhci_host_model
`default_nettype wire

// File: sim/lhci_props.sv
// checker bound to the lcd host command interface top
`timescale 1ns/1ns
`default_nettype none
module lhci_props (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        resetn,
   // mcu bus
   input wire logic        bus_style_sel_a,
   input wire logic        bus_style_sel_b,
   input wire logic        host_cs_n,
   input wire logic        register_select,
   input wire logic        host_rd_n_or_dir,
   input wire logic        host_wr_n_or_en,
   input wire logic [7:0]  host_data_in,
   input wire logic [7:0]  host_data_out,
   input wire logic        host_data_oe,
   // display side
   input wire logic        retrace_in,
   input wire logic        cursor_shown,
   input wire logic        block1_graphics_sel,
   input wire logic        block3_graphics_sel,
   input wire logic [3:0]  block_graphics,
   input wire logic [2:0]  pixel_scroll,
   input wire logic [15:0] cursor_addr,
   input wire logic        sleep_active,
   // memory port and wishbone
   input wire logic [15:0] vram_addr,
   input wire logic        vram_we,
   input wire logic        vram_re,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o
);
   // access terms as each strobe style decodes them
   wire en_style = bus_style_sel_a & ~bus_style_sel_b;
   wire acc_rd = ~host_cs_n & (en_style ? host_wr_n_or_en & host_rd_n_or_dir : ~host_rd_n_or_dir);
   wire acc_wr = ~host_cs_n & (en_style ? host_wr_n_or_en & ~host_rd_n_or_dir : ~host_wr_n_or_en);
   logic rd_q;
   logic wr_q;
   wire rd_tk = acc_rd & ~rd_q;
   wire wr_tk = acc_wr & ~wr_q;
   // previous access terms, so a held strobe counts once
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         rd_q <= acc_rd;
         wr_q <= acc_wr;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_wb_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   AST_WB_ACK: assert property (s_wb_take |=> s_ack_pulse)
      else $error("wishbone ack not a single pulse after the request");
   AST_BLK_GFX: assert property (block_graphics == {1'b1, block3_graphics_sel, 1'b1, block1_graphics_sel})
      else $error("block mode vector wrong");
   AST_OE: assert property (acc_rd |-> host_data_oe)
      else $error("read access without output enable");
   AST_STATUS: assert property (rd_tk && !register_select |=> host_data_out == {1'b0, $past(retrace_in), 6'h00})
      else $error("status byte does not show retrace");
   AST_STORE: assert property (vram_we |-> vram_addr == $past(cursor_addr) ##1 !vram_we)
      else $error("store not at cursor or not a pulse");
   AST_FETCH: assert property (vram_re && !cursor_shown && !$past(cursor_shown) |-> vram_addr == cursor_addr)
      else $error("fetch address is not the cursor");
   AST_CURSOR: assert property (!$stable(cursor_addr) |-> vram_we || vram_re || $past(wr_tk))
      else $error("cursor moved without load or access");
   AST_SLEEP: assert property (sleep_active && wr_tk && !(register_select && host_data_in == 8'h40) |=> $stable(cursor_addr) && $stable(pixel_scroll))
      else $error("write took effect while asleep");
endmodule // lhci_props

bind lhci_top lhci_props u_props (
   .sys_clk, .resetn, .bus_style_sel_a, .bus_style_sel_b, .host_cs_n, .register_select,
   .host_rd_n_or_dir, .host_wr_n_or_en, .host_data_in, .host_data_out, .host_data_oe,
   .retrace_in, .cursor_shown, .block1_graphics_sel, .block3_graphics_sel, .block_graphics,
   .pixel_scroll, .cursor_addr, .sleep_active, .vram_addr, .vram_we, .vram_re,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o
);
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the lcd host command interface
`timescale 1ns/1ns
`default_nettype none
module tb;
   typedef struct {string nm; logic [31:0] v;} lhci_note_type;
   lhci_note_type notes[$];
   logic sys_clk, resetn, sel_a, sel_b, retrace, shown, wb_cyc, wb_stb, wb_we;
   logic [7:0] wb_adr, rnd, vram_rdata;
   logic [31:0] wb_dat;
   wire logic cs_n, rs, rdd, wre, rd_done, ack, vwe, vre;
   wire logic [7:0] hdin, hdout, rd_byte, vwd;
   wire logic [15:0] vaddr;
   wire logic [9:0] pins;
   wire logic [31:0] wb_q;
   int fail_count, tests_run, cycles;

   lhci_top dut (.sys_clk, .resetn, .bus_style_sel_a(sel_a), .bus_style_sel_b(sel_b),
      .host_cs_n(cs_n), .register_select(rs), .host_rd_n_or_dir(rdd), .host_wr_n_or_en(wre),
      .host_data_in(hdin), .host_data_out(hdout), .host_data_oe(), .retrace_in(retrace),
      .cursor_shown(shown), .block1_graphics_sel(), .block3_graphics_sel(),
      .block_graphics(pins[8:5]), .three_layer_sel(pins[9]), .compose_method(pins[4:3]),
      .pixel_scroll(pins[2:0]), .cursor_addr(), .sleep_active(),
      .vram_addr(vaddr), .vram_wdata(vwd), .vram_we(vwe), .vram_re(vre), .vram_rdata,
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(4'h3), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(ack));
   lhci_host_model host (.sys_clk, .style_en(sel_a & ~sel_b), .cs_n, .rs, .rd_dir(rdd), .wr_en(wre),
      .dout(hdin), .din(hdout), .rd_done, .rd_byte);

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // memory contents are a pattern of the address
   function automatic logic [7:0] fv(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic note(input string nm, input logic [31:0] v);
      notes.push_back('{nm, v});
   endtask
   task automatic take(input logic [31:0] seen);
      lhci_note_type n;
      n = (notes.size() == 0) ? '{"unexpected result", 32'hx} : notes.pop_front();
      check(n.nm, seen, n.v);
   endtask
   // classic single cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      @(posedge sys_clk);
      while (!ack) @(posedge sys_clk);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_dat <= ~d;
   endtask
   task automatic wbr(input string nm, input logic [7:0] a, input logic [31:0] exp);
      note(nm, exp);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic load(input logic [15:0] c);
      host.acc(1'b1, 1'b0, 8'h46);
      host.acc(1'b0, 1'b0, c[7:0]);
      host.acc(1'b0, 1'b0, c[15:8]);
   endtask
   task automatic close_out();
      if (fail_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // display memory answers one cycle after a fetch, scrambles otherwise
   always @(posedge sys_clk) vram_rdata <= vre ? fv(vaddr) : ~vram_rdata;
   // results are compared in the order they were noted
   always @(posedge sys_clk) begin
      if (rd_done) take({24'h0, rd_byte});
      if (vwe) take({8'h0, vaddr, vwd});
      if (ack && !wb_we) take(wb_q);
   end
   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      int i, d, k;
      logic [15:0] a, c;
      logic [4:0] ov;
      logic b;
      {resetn, sel_a, sel_b, retrace, shown, wb_cyc, wb_stb, wb_we} = 8'h00;
      wb_adr = 8'h00;
      wb_dat = 32'h0;
      vram_rdata = 8'h00;
      rnd = 8'h39;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      // reset values, unmapped place, pitch write
      wbr("pitch", 8'h08, 32'h28);
      wbr("cursor", 8'h04, 32'h0);
      wbr("mode", 8'h0c, 32'h0);
      wbr("state", 8'h00, 32'h2);
      wb(1'b1, 8'h10, 32'hffff);
      wbr("unmapped", 8'h10, 32'h0);
      wb(1'b1, 8'h08, 32'h10);
      wbr("pitch", 8'h08, 32'h10);
      for (i = 0; i < 2; i++) begin
         retrace <= i[0];
         note("status", {25'h0, i[0], 6'h0});
         host.acc(1'b0, 1'b1, 8'h00);
      end
      // system setup first, sent as a lone command byte
      host.acc(1'b1, 1'b0, 8'h40);
      // overlay, scroll and each step direction
      for (i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         b = rnd[0];
         ov = {b & rnd[1], b, b, rnd[3:2]};
         host.acc(1'b1, 1'b0, 8'h5b);
         host.acc(1'b0, 1'b0, {3'h0, ov});
         host.acc(1'b1, 1'b0, 8'h5a);
         host.acc(1'b0, 1'b0, {5'h0, rnd[6:4]});
         host.acc(1'b1, 1'b0, 8'h4c + i[7:0]);
         wbr("mode", 8'h0c, {19'h0, i[1:0], rnd[6:4], ov, 3'h0});
         check("pins", pins, {ov[4], 1'b1, ov[3], 1'b1, ov[2:0], rnd[6:4]});
      end
      // cursor load and readback under every select pin setting
      for (i = 0; i < 5; i++) begin
         {sel_b, sel_a} <= i[1:0];
         @(posedge sys_clk);
         host.idle();
         if (i == 4) break;
         rnd = lfsr(rnd);
         c = {rnd, lfsr(rnd)};
         load(c);
         wbr("cursor", 8'h04, {16'h0, c});
         host.acc(1'b1, 1'b0, 8'h47);
         note("cursor low", {24'h0, c[7:0]});
         host.acc(1'b1, 1'b1, 8'h00);
         note("cursor high", {24'h0, c[15:8]});
         host.acc(1'b1, 1'b1, 8'h00);
      end
      // stores in all four directions, cursor carries on
      a = 16'h1234;
      load(a);
      for (d = 0; d < 4; d++) begin
         host.acc(1'b1, 1'b0, 8'h4c + d[7:0]);
         host.acc(1'b1, 1'b0, 8'h42);
         for (k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            note("store", {8'h0, a, rnd});
            host.acc(1'b0, 1'b0, rnd);
            a = (d == 0) ? a + 16'h1 : (d == 1) ? a - 16'h1 : (d == 2) ? a - 16'h10 : a + 16'h10;
         end
      end
      wbr("cursor", 8'h04, {16'h0, a});
      // fetch prefetches, then one step per read
      load(16'h0200);
      host.acc(1'b1, 1'b0, 8'h4c);
      host.acc(1'b1, 1'b0, 8'h43);
      for (k = 0; k < 3; k++) begin
         note("fetch", {24'h0, fv(16'h0200 + k[15:0])});
         host.acc(1'b1, 1'b1, 8'h00);
      end
      wbr("cursor", 8'h04, 32'h0203);
      shown <= 1'b1;
      load(16'h0300);
      host.acc(1'b1, 1'b0, 8'h43);
      note("fetch ahead", {24'h0, fv(16'h0302)});
      host.acc(1'b1, 1'b1, 8'h00);
      shown <= 1'b0;
      // scrolling and sleep leave the cursor alone
      host.acc(1'b1, 1'b0, 8'h5a);
      host.acc(1'b0, 1'b0, 8'h05);
      wbr("cursor", 8'h04, 32'h0301);
      host.acc(1'b1, 1'b0, 8'h53);
      load(16'hbeef);
      wbr("cursor", 8'h04, 32'h0301);
      wbr("state", 8'h00, 32'h3);
      host.acc(1'b1, 1'b0, 8'h40);
      wbr("state", 8'h00, 32'h2);
      @(posedge sys_clk);
      if (notes.size() != 0) fail_count++;
      close_out();
   end
endmodule // tb
`default_nettype wire
